// file: hw/tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define TMR_IDX_CTL      6'h33
`define TMR_IDX_CNT      6'h32
`define TMR_IDX_CMP      6'h31
`define TMR_IDX_FLG      6'h34

// ----------------------------------------------------------------------------
// timer_control field positions
// ----------------------------------------------------------------------------
`define TMR_CTL_FORCE    7
`define TMR_CTL_WM0      6
`define TMR_CTL_COM1     5
`define TMR_CTL_COM0     4
`define TMR_CTL_WM1      3
`define TMR_CTL_CS_HI    2
`define TMR_CTL_CS_LO    0

// ----------------------------------------------------------------------------
// flag register field positions
// ----------------------------------------------------------------------------
`define TMR_FLG_OVF      0
`define TMR_FLG_CMP      1

// ----------------------------------------------------------------------------
// reset values and counter limits
// ----------------------------------------------------------------------------
`define TMR_CTL_RST      7'h00
`define TMR_CNT_RST      8'h00
`define TMR_CMP_RST      8'h00
`define TMR_MAX          8'hFF
`define TMR_BOTTOM       8'h00

// ----------------------------------------------------------------------------
// prescaler masks: divide by 1, 8, 32, 64, 128, 256, 1024
// ----------------------------------------------------------------------------
`define TMR_PRE_W        10
`define TMR_MASK_1       10'h000
`define TMR_MASK_8       10'h007
`define TMR_MASK_32      10'h01F
`define TMR_MASK_64      10'h03F
`define TMR_MASK_128     10'h07F
`define TMR_MASK_256     10'h0FF
`define TMR_MASK_1024    10'h3FF

`endif

// file: hw/tmr_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmr_consts.svh"

// Overview of operation
// [R01] force strobe acts only in normal or clear-on-match mode
// [R02] force strobe makes an immediate match, pin follows compare_out_mode
// [R03] forced match sets no flag and never clears the counter
// [R04] force strobe bit reads back as zero
// [R05] software writes force strobe as zero while a pwm mode is chosen
// [R06] wave_mode_select at bits 6 and 3: normal, phase pwm, clear, fast pwm
// [R07] top is 0xFF except clear-on-match mode, where top is compare_value
// [R08] compare buffer load timing per mode; overflow at max, phase pwm at bottom
// [R09] nonzero compare_out_mode gives waveform the pin; software sets direction
// [R10] non-pwm compare_out_mode: off, toggle, clear, set on match
// [R11] fast pwm: off, reserved, clear match set bottom, set match clear bottom
// [R12] fast pwm, compare at top: match ignored, bottom action kept
// [R13] phase pwm: clear up-match set down-match, or inverse; 01 reserved
// [R14] phase pwm, compare at top: match ignored, action done at top
// [R15] clock_select_field: stop, undivided, then divide 8 to 1024
// [R16] count_value is read and written directly by software
// [R17] count_value write blocks the match on the next timer tick
// [R18] compare_value checked every tick, match raises flag and drives waveform
// [R19] fast pwm counts to max then clears on next tick
// [R20] phase pwm counts up to max, turns there with no hold tick, counts down to bottom
// [R21] clear mode clears after a match, normal mode wraps 0xFF to zero
module tmr_core
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // port pin
  input  wire logic              port_out_i,
  input  wire logic              port_dir_i,
  output logic                   waveform_output_pin_o,
  output logic                   waveform_output_pin_oe_n_o,
  // status
  output logic                   overflow_flag_o,
  output logic                   compare_flag_o
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
    hit = (a[7:2] == idx);
  endfunction

  function automatic logic [`TMR_PRE_W-1:0] pre_mask(input logic [2:0] cs);
    case (cs)
      3'h1:    pre_mask = `TMR_MASK_1;
      3'h2:    pre_mask = `TMR_MASK_8;
      3'h3:    pre_mask = `TMR_MASK_32;
      3'h4:    pre_mask = `TMR_MASK_64;
      3'h5:    pre_mask = `TMR_MASK_128;
      3'h6:    pre_mask = `TMR_MASK_256;
      default: pre_mask = `TMR_MASK_1024;
    endcase
  endfunction

  function automatic logic match_act(input logic [1:0] com, input logic oc);
    case (com)
      2'b01:   match_act = ~oc;
      2'b10:   match_act = 1'b0;
      2'b11:   match_act = 1'b1;
      default: match_act = oc;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic [6:0]            ctl_q;
  logic [7:0]            cnt_q;
  logic [7:0]            buf_q;
  logic [7:0]            ocr_q;
  logic [`TMR_PRE_W-1:0] pre_q;
  logic                  blk_q;
  logic                  ovf_q;
  logic                  cmpf_q;
  logic                  oc_q;
  logic                  pin_q;
  logic                  oe_n_q;
  tmr_dir_t              dir_q;
  tmr_mode_t             mode;
  logic [1:0]            com;
  logic [2:0]            cs;
  logic                  acc;
  logic                  wr;
  logic                  wr_ctl;
  logic                  wr_cnt;
  logic                  wr_cmp;
  logic                  wr_flg;
  logic [7:0]            wdat;
  logic                  force_ok;
  logic                  tick;
  logic                  at_max;
  logic                  match_ev;
  logic                  top_case;
  logic                  ovf_set;
  logic [7:0]            rd_val;

  // --------------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------------
  assign mode     = tmr_mode_t'({ctl_q[`TMR_CTL_WM1], ctl_q[`TMR_CTL_WM0]}); // R06
  assign com      = ctl_q[`TMR_CTL_COM1:`TMR_CTL_COM0];
  assign cs       = ctl_q[`TMR_CTL_CS_HI:`TMR_CTL_CS_LO];
  assign wdat     = dat_i[7:0];
  assign at_max   = (cnt_q == `TMR_MAX);
  assign top_case = com[1] && (ocr_q == `TMR_MAX);

  // --------------------------------------------------------------------------
  // wishbone slave
  // --------------------------------------------------------------------------
  assign acc    = cyc_i & stb_i & ack_q;
  assign wr     = acc & we_i & sel_i[0];
  assign wr_ctl = wr & hit(adr_i, `TMR_IDX_CTL);
  assign wr_cnt = wr & hit(adr_i, `TMR_IDX_CNT);
  assign wr_cmp = wr & hit(adr_i, `TMR_IDX_CMP);
  assign wr_flg = wr & hit(adr_i, `TMR_IDX_FLG);
  assign ack_o  = ack_q;
  assign dat_o  = dat_q;

  always_comb begin
    rd_val = 8'h00;
    if (hit(adr_i, `TMR_IDX_CTL)) begin
      rd_val = {1'b0, ctl_q}; // R04
    end else if (hit(adr_i, `TMR_IDX_CNT)) begin
      rd_val = cnt_q; // R16
    end else if (hit(adr_i, `TMR_IDX_CMP)) begin
      rd_val = buf_q;
    end else if (hit(adr_i, `TMR_IDX_FLG)) begin
      rd_val = {6'h00, cmpf_q, ovf_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      if (cyc_i & stb_i & ~ack_q) begin
        dat_q <= {24'h00_0000, rd_val};
      end
    end
  end

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `TMR_CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= wdat[6:0];
    end
  end

  // --------------------------------------------------------------------------
  // prescaler and timer tick
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || cs == 3'h0) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  assign tick = (cs != 3'h0) && ((pre_q & pre_mask(cs)) == pre_mask(cs)); // R15

  // --------------------------------------------------------------------------
  // compare unit
  // --------------------------------------------------------------------------
  assign match_ev = tick && (cnt_q == ocr_q) && !blk_q; // R18

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_q <= 1'b0;
    end else if (wr_cnt) begin
      blk_q <= 1'b1; // R17
    end else if (tick) begin
      blk_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q <= `TMR_CMP_RST;
    end else if (wr_cmp) begin
      buf_q <= wdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocr_q <= `TMR_CMP_RST;
    end else if (mode == TMR_MODE_NORMAL || mode == TMR_MODE_CLEAR) begin
      ocr_q <= wr_cmp ? wdat : buf_q; // R08
    end else if (tick && at_max) begin
      ocr_q <= buf_q; // R08
    end
  end

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `TMR_CNT_RST;
      dir_q <= TMR_DIR_UP;
    end else if (wr_cnt) begin
      cnt_q <= wdat; // R16
    end else if (tick) begin
      case (mode)
        TMR_MODE_CLEAR: begin
          cnt_q <= match_ev ? `TMR_BOTTOM : cnt_q + 8'h01; // R07 R21
        end
        TMR_MODE_PHASE: begin
          if (dir_q == TMR_DIR_UP) begin
            if (at_max) begin
              dir_q <= TMR_DIR_DN; // R20
              cnt_q <= cnt_q - 8'h01;
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end else begin
            if (cnt_q == `TMR_BOTTOM) begin
              dir_q <= TMR_DIR_UP; // R20
              cnt_q <= cnt_q + 8'h01;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        default: begin
          cnt_q <= cnt_q + 8'h01; // R19 R21
          dir_q <= TMR_DIR_UP;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // flags, write one clears, a set in the same cycle wins
  // --------------------------------------------------------------------------
  assign ovf_set = tick && ((mode == TMR_MODE_PHASE) ?
                   (cnt_q == `TMR_BOTTOM && dir_q == TMR_DIR_DN) : at_max); // R08

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_q  <= 1'b0;
      cmpf_q <= 1'b0;
    end else begin
      ovf_q  <= ovf_set | (ovf_q & ~(wr_flg & wdat[`TMR_FLG_OVF]));
      cmpf_q <= match_ev | (cmpf_q & ~(wr_flg & wdat[`TMR_FLG_CMP])); // R03 R18
    end
  end

  assign overflow_flag_o = ovf_q;
  assign compare_flag_o  = cmpf_q;

  // --------------------------------------------------------------------------
  // waveform unit
  // --------------------------------------------------------------------------
  assign force_ok = wr_ctl && wdat[`TMR_CTL_FORCE] && !wdat[`TMR_CTL_WM0]; // R01

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_q <= 1'b0;
    end else if (force_ok) begin
      oc_q <= match_act(wdat[`TMR_CTL_COM1:`TMR_CTL_COM0], oc_q); // R02 R03
    end else if (tick) begin
      case (mode)
        TMR_MODE_FAST: begin
          if (com[1] && at_max) begin
            oc_q <= ~com[0]; // R11 R12
          end else if (com[1] && match_ev && !top_case) begin
            oc_q <= com[0]; // R11
          end
        end
        TMR_MODE_PHASE: begin
          if (top_case) begin
            if (at_max) begin
              oc_q <= ~com[0]; // R14
            end
          end else if (com[1] && match_ev) begin
            // a match at bottom acts as up-counting, so compare zero stays steady
            oc_q <= (dir_q == TMR_DIR_UP || cnt_q == `TMR_BOTTOM) ? com[0] : ~com[0]; // R13
          end
        end
        default: begin
          if (match_ev) begin
            oc_q <= match_act(com, oc_q); // R10
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q  <= (com != 2'b00) ? oc_q : port_out_i; // R09
      oe_n_q <= ~port_dir_i; // R09
    end
  end

  assign waveform_output_pin_o      = pin_q;
  assign waveform_output_pin_oe_n_o = oe_n_q;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic                  chk_cnt_wr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_cnt_wr_q <= 1'b0;
    end else if (wr_cnt) begin
      chk_cnt_wr_q <= 1'b1;
    end else if (tick) begin
      chk_cnt_wr_q <= 1'b0;
    end
  end

  sequence s_tick_after_write;
    chk_cnt_wr_q && tick && (cnt_q == ocr_q);
  endsequence

  sequence s_force_pwm;
    wr_ctl && wdat[`TMR_CTL_FORCE] && wdat[`TMR_CTL_WM0] && !tick;
  endsequence

  sequence s_force_set;
    force_ok && wdat[`TMR_CTL_COM1:`TMR_CTL_COM0] == 2'b11;
  endsequence

  property p_force_pwm_none;
    @(posedge clk_i) disable iff (rst_i)
      s_force_pwm |=> $stable(oc_q);
  endproperty
  a_force_pwm_none: assert property (p_force_pwm_none) else $error("force acted in pwm"); // R01

  property p_force_set;
    @(posedge clk_i) disable iff (rst_i)
      s_force_set |=> oc_q ##1 (pin_q || !$past(com[1]));
  endproperty
  a_force_set: assert property (p_force_set) else $error("forced set missing"); // R02

  property p_force_no_side;
    @(posedge clk_i) disable iff (rst_i)
      force_ok && !tick |=> $stable(cnt_q) && !$rose(cmpf_q);
  endproperty
  a_force_no_side: assert property (p_force_no_side) else $error("force side effect"); // R03

  property p_strobe_reads_zero;
    @(posedge clk_i) disable iff (rst_i)
      ack_q && hit(adr_i, `TMR_IDX_CTL) |-> !dat_o[`TMR_CTL_FORCE];
  endproperty
  a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("strobe read one"); // R04

  property p_clear_top;
    @(posedge clk_i) disable iff (rst_i)
      mode == TMR_MODE_CLEAR && match_ev && !wr_cnt |=> cnt_q == `TMR_BOTTOM;
  endproperty
  a_clear_top: assert property (p_clear_top) else $error("no clear on match"); // R07

  property p_write_blocks;
    @(posedge clk_i) disable iff (rst_i)
      s_tick_after_write |-> !match_ev ##1 !$rose(cmpf_q);
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match not blocked"); // R17

  property p_fast_wrap;
    @(posedge clk_i) disable iff (rst_i)
      mode == TMR_MODE_FAST && tick && at_max && !wr_cnt |=> cnt_q == `TMR_BOTTOM;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm wrap"); // R19

  property p_phase_turn;
    @(posedge clk_i) disable iff (rst_i)
      mode == TMR_MODE_PHASE && tick && at_max && dir_q == TMR_DIR_UP && !wr_cnt
      |=> dir_q == TMR_DIR_DN && cnt_q == 8'hFE;
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("phase turn"); // R20

  property p_undivided;
    @(posedge clk_i) disable iff (rst_i)
      cs == 3'h1 |-> tick;
  endproperty
  a_undivided: assert property (p_undivided) else $error("undivided tick missing"); // R15

  property p_div8;
    @(posedge clk_i) disable iff (rst_i)
      cs == 3'h2 && tick && $stable(cs) |=> (!tick || cs != 3'h2) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 wrong"); // R15

  property p_ovf_phase;
    @(posedge clk_i) disable iff (rst_i)
      mode == TMR_MODE_PHASE && tick && at_max |=> !$rose(ovf_q);
  endproperty
  a_ovf_phase: assert property (p_ovf_phase) else $error("phase overflow at max"); // R08

endmodule

`default_nettype wire

// file: hw/tmr_pkg.sv
package tmr_pkg;

  // --------------------------------------------------------------------------
  // wave modes, code is {bit 3, bit 6} of timer_control
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_MODE_NORMAL = 2'h0,
    TMR_MODE_PHASE  = 2'h1,
    TMR_MODE_CLEAR  = 2'h2,
    TMR_MODE_FAST   = 2'h3
  } tmr_mode_t;

  // --------------------------------------------------------------------------
  // count direction state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_DIR_UP = 2'b01,
    TMR_DIR_DN = 2'b10
  } tmr_dir_t;

endpackage

// file: test/timer8_control_compare_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmr_consts.svh"
module timer8_control_compare_bench
  import tmr_pkg::*;
;
  // ---------------------------------------------------------------------------
  // design ports
  // ---------------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        port_out_i = 1'b0;
  logic        port_dir_i = 1'b0;
  logic        pin;
  logic        oe_n;
  logic        ovf;
  logic        cmpf;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  r;
  logic [7:0]  r2;
  int          e;
  int          hi;
  int          win;

  tmr_core dut (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .cyc_i                      (cyc_i),
    .stb_i                      (stb_i),
    .we_i                       (we_i),
    .adr_i                      (adr_i),
    .sel_i                      (sel_i),
    .dat_i                      (dat_i),
    .dat_o                      (dat_o),
    .ack_o                      (ack_o),
    .port_out_i                 (port_out_i),
    .port_dir_i                 (port_dir_i),
    .waveform_output_pin_o      (pin),
    .waveform_output_pin_oe_n_o (oe_n),
    .overflow_flag_o            (ovf),
    .compare_flag_o             (cmpf)
  );

  // ---------------------------------------------------------------------------
  // clock, timeout, reporting
  // ---------------------------------------------------------------------------
  always #5 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic int near(input int s, input int x, input int t);
    return (s >= x - t && s <= x + t) ? x : s;
  endfunction

  // ---------------------------------------------------------------------------
  // wishbone classic master
  // ---------------------------------------------------------------------------
  task automatic wb(input logic w, input logic [5:0] idx, input logic [3:0] sel,
                    input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= sel;
    dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    check("ack", ack_o, 1'b1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, idx, 4'hF, wd, d);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] v);
    wb(1'b0, idx, 4'hF, 8'h00, v);
  endtask

  // ---------------------------------------------------------------------------
  // tables
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] idx;
    logic [3:0] sel;
    logic [7:0] wd;
    logic [7:0] rd;
  } tmr_row_t;
  tmr_row_t   rows [6] = '{
    '{`TMR_IDX_CMP, 4'hF, 8'h5A, 8'h5A},
    '{`TMR_IDX_CMP, 4'hE, 8'h11, 8'h5A},
    '{`TMR_IDX_CNT, 4'hF, 8'hA5, 8'hA5},
    '{`TMR_IDX_CTL, 4'hF, 8'hF8, 8'h78},
    '{`TMR_IDX_CTL, 4'hF, 8'h80, 8'h00},
    '{6'h00,        4'hF, 8'hFF, 8'h00}};
  int         divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] fctl [6] = '{8'h90, 8'hA0, 8'hB0, 8'h98, 8'hA8, 8'hB8};
  logic       fpin [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] pctl [8] = '{8'h69, 8'h79, 8'h69, 8'h69, 8'h61, 8'h71, 8'h61, 8'h61};
  logic [7:0] pcmp [8] = '{8'h80, 8'h80, 8'hFF, 8'h00, 8'h80, 8'h80, 8'hFF, 8'h00};
  int         phi  [8] = '{258, 254, 512, 2, 256, 254, 510, 0};

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    check("reset_out", {ack_o, pin, oe_n, ovf, cmpf}, 5'b00100);
    rst_i <= 1'b0;
    rd(`TMR_IDX_CTL, r);
    check("ctl_reset", r, 8'h00);
    rd(`TMR_IDX_CNT, r);
    check("cnt_reset", r, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, rows[i].idx, rows[i].sel, rows[i].wd, r);
      rd(rows[i].idx, r);
      check("reg_row", r, rows[i].rd);
    end
    for (int cs = 1; cs < 8; cs++) begin
      wr(`TMR_IDX_CNT, 8'h00);
      wr(`TMR_IDX_CTL, cs[7:0]);
      repeat (20 * divs[cs]) @(posedge clk_i);
      wr(`TMR_IDX_CTL, 8'h00);
      rd(`TMR_IDX_CNT, r);
      e = (20 * divs[cs] + 3) / divs[cs];
      check("count_div", near(int'(r), e, 1), e);
    end
    repeat (40) @(posedge clk_i);
    rd(`TMR_IDX_CNT, r2);
    check("count_stop", r2, r);
    wr(`TMR_IDX_FLG, 8'h03);
    wr(`TMR_IDX_CNT, 8'hFE);
    wr(`TMR_IDX_CTL, 8'h01);
    wr(`TMR_IDX_CTL, 8'h00);
    rd(`TMR_IDX_CNT, r);
    check("wrap", r < 8'h04, 1'b1);
    check("ovf_max", ovf, 1'b1);
    wr(`TMR_IDX_FLG, 8'h03);
    wr(`TMR_IDX_CNT, 8'h00);
    wr(`TMR_IDX_CMP, 8'h10);
    port_dir_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(`TMR_IDX_CTL, fctl[i]);
      repeat (2) @(posedge clk_i);
      check("force_pin", pin, fpin[i]);
    end
    check("force_flag", cmpf, 1'b0);
    rd(`TMR_IDX_CNT, r);
    check("force_cnt", r, 8'h00);
    wr(`TMR_IDX_CTL, 8'hE0);
    wr(`TMR_IDX_CTL, 8'hE8);
    repeat (2) @(posedge clk_i);
    check("force_pwm", pin, 1'b1);
    rd(`TMR_IDX_CTL, r);
    check("force_read", r, 8'h68);
    wr(`TMR_IDX_CTL, 8'h80);
    port_out_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("port_hi", pin, 1'b1);
    port_out_i <= 1'b0;
    port_dir_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("port_lo", {pin, oe_n}, 2'b01);
    port_dir_i <= 1'b1;
    wr(`TMR_IDX_FLG, 8'h03);
    wr(`TMR_IDX_CMP, 8'h05);
    wr(`TMR_IDX_CNT, 8'h05);
    wr(`TMR_IDX_CTL, 8'h09);
    wr(`TMR_IDX_CTL, 8'h00);
    rd(`TMR_IDX_CNT, r);
    check("blocked", {r > 8'h05, cmpf}, 2'b10);
    wr(`TMR_IDX_CNT, 8'h00);
    wr(`TMR_IDX_CTL, 8'h09);
    repeat (100) @(posedge clk_i);
    wr(`TMR_IDX_CTL, 8'h00);
    rd(`TMR_IDX_CNT, r);
    check("ctc_top", r <= 8'h05, 1'b1);
    check("ctc_flags", {cmpf, ovf}, 2'b10);
    for (int i = 0; i < 8; i++) begin
      wr(`TMR_IDX_CTL, 8'h00);
      wr(`TMR_IDX_CMP, pcmp[i]);
      wr(`TMR_IDX_CNT, 8'h00);
      wr(`TMR_IDX_FLG, 8'h03);
      wr(`TMR_IDX_CTL, pctl[i]);
      repeat (600) @(posedge clk_i);
      win = pctl[i][3] ? 512 : 510;
      hi = 0;
      for (int k = 0; k < win; k++) begin
        @(posedge clk_i);
        hi += (pin === 1'b1);
      end
      check("pwm_high", near(hi, phi[i], 3), phi[i]);
      check("pwm_ovf", ovf, 1'b1);
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("reset_mid", {ack_o, pin, oe_n, ovf, cmpf}, 5'b00100);
    rd(`TMR_IDX_CTL, r);
    check("ctl_mid", r, 8'h00);
    rd(`TMR_IDX_CNT, r);
    check("cnt_mid", r, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
